// *** hdl/tatpg_pkg.sv ***
// Constants and carrier types of the transmit alarm and test pattern block
package tatpg_pkg;

  localparam logic [7:0] ADDR_TX_ALARM_CONFIG = 8'h75;
  localparam logic [7:0] ADDR_TX_TEST_PATTERN_CONFIG = 8'h76;
  localparam logic [7:0] ADDR_TX_LOOP_CODE_CONFIG = 8'h77;
  localparam logic [7:0] ADDR_TX_LOOP_CODE_PATTERN = 8'h78;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam logic [7:0] T1_FRAME_BIT_POS = 8'h00;
  localparam logic [7:0] T1_LAST_POS = 8'hC0;
  localparam logic [4:0] E1_TS_FRAMING = 5'h00;
  localparam logic [4:0] E1_TS_CAS = 5'h10;
  localparam logic [2:0] LOOP_LEN_LAST_BASE = 3'h3;
  localparam logic [2:0] LOOP_FIRST_BIT = 3'h7;
  localparam logic [3:0] ZERO_LIMIT_SHORT = 4'h7;
  localparam logic [3:0] ZERO_LIMIT_LONG = 4'hE;
  localparam logic [4:0] PRBS_LEN_11 = 5'h0B;
  localparam logic [4:0] PRBS_LEN_15 = 5'h0F;
  localparam logic [4:0] PRBS_LEN_20 = 5'h14;
  localparam logic [4:0] PRBS_LEN_23 = 5'h17;
  localparam logic [4:0] PRBS_TAP_11 = 5'h09;
  localparam logic [4:0] PRBS_TAP_15 = 5'h0E;
  localparam logic [4:0] PRBS_TAP_20 = 5'h11;
  localparam logic [4:0] PRBS_TAP_23 = 5'h12;
  localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;

  // Pin synchroniser lanes
  localparam int PIN_TX_CLK = 0;
  localparam int PIN_ALT_CLK = 1;
  localparam int PIN_FRAME_SYNC = 2;
  localparam int PIN_SYS_DATA = 3;
  localparam int PIN_RX_LOOP = 4;
  localparam int PIN_RA_POS = 5;
  localparam int PIN_MF_POS = 6;
  localparam int PIN_COUNT = 7;

  typedef struct packed {
    logic [1:0] reserved;
    logic auto_mf_remote_alarm;
    logic auto_remote_alarm;
    logic auto_all_ones_alarm;
    logic manual_mf_remote_alarm;
    logic manual_remote_alarm;
    logic manual_all_ones_alarm;
  } tatpg_alarm_cfg_s;

  typedef struct packed {
    logic [2:0] reserved;
    logic pattern_tx_enable;
    logic framed;
    logic zero_run_limit_en;
    logic [1:0] prbs_length_select;
  } tatpg_pattern_cfg_s;

  typedef struct packed {
    logic [3:0] reserved;
    logic [1:0] loop_code_length;
    logic unframed;
    logic loop_code_start;
  } tatpg_loop_cfg_s;

  typedef struct packed {
    logic t1_mode;
    logic cas_framing;
    logic remote_alarm_insert_en;
    logic mf_remote_alarm_insert_en;
    logic alarm_clock_switch_en;
    logic digital_line_select;
    logic line_loopback;
  } tatpg_mode_s;

  typedef struct packed {
    logic rx_signal_loss;
    logic rx_clock_loss;
    logic rx_frame_align_loss;
    logic rx_cas_align_loss;
    logic tx_clock_loss;
  } tatpg_loss_s;

endpackage : tatpg_pkg

// *** hdl/tatpg_prbs.sv ***
// PRBS generator with inversion and zero run limiting
`timescale 1ns/100ps
`default_nettype none
module tatpg_prbs (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  input wire logic step_in,
  input wire logic [1:0] sel_in,
  input wire logic zero_limit_in,
  output logic bit_out
);
  import tatpg_pkg::*;

  function automatic logic [4:0] len_of(input logic [1:0] sel);
    case (sel)
      2'h0: len_of = PRBS_LEN_11;
      2'h1: len_of = PRBS_LEN_15;
      2'h2: len_of = PRBS_LEN_20;
      default: len_of = PRBS_LEN_23;
    endcase
  endfunction : len_of

  function automatic logic [4:0] tap_of(input logic [1:0] sel);
    case (sel)
      2'h0: tap_of = PRBS_TAP_11;
      2'h1: tap_of = PRBS_TAP_15;
      2'h2: tap_of = PRBS_TAP_20;
      default: tap_of = PRBS_TAP_23;
    endcase
  endfunction : tap_of

  logic [22:0] lfsr;
  logic [3:0] zero_run;
  wire logic [4:0] len_idx = len_of(sel_in) - 5'h01;
  wire logic [4:0] tap_idx = tap_of(sel_in) - 5'h01;
  wire logic feedback = lfsr[len_idx] ^ lfsr[tap_idx];
  // Zero limiting sends the pattern noninverted
  wire logic invert = !zero_limit_in && sel_in[0];
  wire logic [3:0] zero_limit = sel_in[1] ? ZERO_LIMIT_LONG : ZERO_LIMIT_SHORT;
  wire logic force_one = zero_limit_in && (zero_run >= zero_limit);

  assign bit_out = force_one | (feedback ^ invert);

  // Reseed while idle so a dead all-zero state can never persist
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lfsr <= PRBS_SEED;
      zero_run <= 4'h0;
    end else if (!run_in) begin
      lfsr <= PRBS_SEED;
      zero_run <= 4'h0;
    end else if (step_in) begin
      lfsr <= {lfsr[21:0], feedback};
      zero_run <= bit_out ? 4'h0 : zero_run + 4'h1;
    end
  end

endmodule : tatpg_prbs
`default_nettype wire

// *** hdl/tatpg_tx_alarm.sv ***
// Transmit alarm, AIS, PRBS and in-band loop code generator
`timescale 1ns/100ps
`default_nettype none
module tatpg_tx_alarm (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic [7:0] cpu_rdata_out,
  input wire logic tx_clock_in,
  input wire logic alternate_tx_clock_in,
  input wire logic frame_sync_in,
  input wire logic sys_tx_data_in,
  input wire logic rx_loop_data_in,
  input wire logic remote_alarm_pos_in,
  input wire logic mf_remote_alarm_pos_in,
  input wire tatpg_pkg::tatpg_mode_s mode_in,
  input wire tatpg_pkg::tatpg_loss_s loss_in,
  output logic line_data_out,
  output logic framer_loop_data_out,
  output logic tx_clock_out,
  output logic all_ones_alarm_out,
  output logic remote_alarm_out,
  output logic mf_remote_alarm_out
);
  import tatpg_pkg::*;

  tatpg_alarm_cfg_s tx_alarm_config;
  tatpg_pattern_cfg_s tx_test_pattern_config;
  tatpg_loop_cfg_s tx_loop_code_config;
  logic [7:0] tx_loop_code_pattern;

  // Register port decode
  wire logic hit_alarm = cpu_addr_in == ADDR_TX_ALARM_CONFIG;
  wire logic hit_pattern = cpu_addr_in == ADDR_TX_TEST_PATTERN_CONFIG;
  wire logic hit_loop_cfg = cpu_addr_in == ADDR_TX_LOOP_CODE_CONFIG;
  wire logic hit_loop_pat = cpu_addr_in == ADDR_TX_LOOP_CODE_PATTERN;
  wire logic [7:0] read_mux =
    hit_alarm ? {2'h0, tx_alarm_config[5:0]} :
    hit_pattern ? {3'h0, tx_test_pattern_config[4:0]} :
    hit_loop_cfg ? {4'h0, tx_loop_code_config[3:0]} :
    hit_loop_pat ? {tx_loop_code_pattern[7:1], 1'b0} : READ_UNMAPPED;

  // Reserved bits are dropped on write and read back as zero
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_alarm_config <= REG_RESET;
      tx_test_pattern_config <= REG_RESET;
      tx_loop_code_config <= REG_RESET;
      tx_loop_code_pattern <= REG_RESET;
    end else if (cpu_wr_in) begin
      if (hit_alarm) tx_alarm_config <= {2'h0, cpu_wdata_in[5:0]};
      if (hit_pattern) tx_test_pattern_config <= {3'h0, cpu_wdata_in[4:0]};
      if (hit_loop_cfg) tx_loop_code_config <= {4'h0, cpu_wdata_in[3:0]};
      if (hit_loop_pat) tx_loop_code_pattern <= {cpu_wdata_in[7:1], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_rdata_out <= READ_UNMAPPED;
    end else if (cpu_rd_in) begin
      cpu_rdata_out <= read_mux;
    end
  end

  // Pin synchronisers; only the second stage is read
  wire logic [PIN_COUNT-1:0] pins_raw = {mf_remote_alarm_pos_in,
    remote_alarm_pos_in, rx_loop_data_in, sys_tx_data_in, frame_sync_in,
    alternate_tx_clock_in, tx_clock_in};
  logic [PIN_COUNT-1:0] pins_meta;
  logic [PIN_COUNT-1:0] pins;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_sync
      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          pins_meta[g] <= 1'b0;
          pins[g] <= 1'b0;
        end else begin
          pins_meta[g] <= pins_raw[g];
          pins[g] <= pins_meta[g];
        end
      end
    end
  endgenerate

  wire logic clk_loss_ais = mode_in.alarm_clock_switch_en &&
    loss_in.tx_clock_loss;
  wire logic use_alt_clk = mode_in.alarm_clock_switch_en &&
    (tx_alarm_config.manual_all_ones_alarm || loss_in.tx_clock_loss);
  wire logic rx_loss = mode_in.digital_line_select ?
    loss_in.rx_clock_loss : loss_in.rx_signal_loss;
  wire logic ais_active = tx_alarm_config.manual_all_ones_alarm ||
    (tx_alarm_config.auto_all_ones_alarm && rx_loss) || clk_loss_ais;

  wire logic remote_active = mode_in.remote_alarm_insert_en &&
    (tx_alarm_config.manual_remote_alarm ||
    (tx_alarm_config.auto_remote_alarm && loss_in.rx_frame_align_loss));
  wire logic mf_active = mode_in.mf_remote_alarm_insert_en &&
    !mode_in.t1_mode && (tx_alarm_config.manual_mf_remote_alarm ||
    (tx_alarm_config.auto_mf_remote_alarm && loss_in.rx_cas_align_loss));

  // Bit clock edges seen on the reference clock; a switch may add one edge
  wire logic sel_clk = use_alt_clk ? pins[PIN_ALT_CLK] : pins[PIN_TX_CLK];
  logic sel_clk_q;
  wire logic bit_strobe = sel_clk && !sel_clk_q;

  logic [7:0] pos_cnt;
  wire logic [7:0] bit_pos = pins[PIN_FRAME_SYNC] ? T1_FRAME_BIT_POS : pos_cnt;
  wire logic [7:0] pos_inc = bit_pos + 8'h01;
  wire logic [7:0] next_pos = (mode_in.t1_mode && bit_pos >= T1_LAST_POS) ?
    T1_FRAME_BIT_POS : pos_inc;
  wire logic framing_pos = mode_in.t1_mode ? (bit_pos == T1_FRAME_BIT_POS) :
    (bit_pos[7:3] == E1_TS_FRAMING);
  wire logic cas_slot = !mode_in.t1_mode && mode_in.cas_framing &&
    (bit_pos[7:3] == E1_TS_CAS);

  wire logic prbs_hold = tx_test_pattern_config.framed &&
    (framing_pos || cas_slot);
  wire logic prbs_use = tx_test_pattern_config.pattern_tx_enable && !prbs_hold;
  wire logic prbs_step = bit_strobe && prbs_use;
  wire logic prbs_bit;

  tatpg_prbs tatpg_prbs_i (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .run_in(tx_test_pattern_config.pattern_tx_enable),
    .step_in(prbs_step),
    .sel_in(tx_test_pattern_config.prbs_length_select),
    .zero_limit_in(tx_test_pattern_config.zero_run_limit_en),
    .bit_out(prbs_bit)
  );

  wire logic loop_use = tx_loop_code_config.loop_code_start &&
    !tx_test_pattern_config.pattern_tx_enable &&
    (tx_loop_code_config.unframed || !framing_pos);
  logic [2:0] loop_idx;
  wire logic [2:0] loop_last = LOOP_LEN_LAST_BASE +
    {1'b0, tx_loop_code_config.loop_code_length};
  wire logic [2:0] loop_bit_sel = LOOP_FIRST_BIT - loop_idx;
  wire logic loop_bit = tx_loop_code_pattern[loop_bit_sel];

  wire logic src_bit = mode_in.line_loopback ? pins[PIN_RX_LOOP] :
    pins[PIN_SYS_DATA];
  wire logic yellow_force = (pins[PIN_RA_POS] && remote_active) ||
    (pins[PIN_MF_POS] && mf_active);
  wire logic payload_bit = prbs_use ? prbs_bit :
    loop_use ? loop_bit : (yellow_force || src_bit);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_clk_q <= 1'b0;
      tx_clock_out <= 1'b0;
    end else begin
      sel_clk_q <= sel_clk;
      tx_clock_out <= sel_clk;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pos_cnt <= T1_FRAME_BIT_POS;
    end else if (bit_strobe) begin
      pos_cnt <= next_pos;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      loop_idx <= 3'h0;
    end else if (!tx_loop_code_config.loop_code_start) begin
      loop_idx <= 3'h0;
    end else if (bit_strobe && loop_use) begin
      loop_idx <= (loop_idx >= loop_last) ? 3'h0 : loop_idx + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_data_out <= 1'b0;
      framer_loop_data_out <= 1'b0;
    end else if (bit_strobe) begin
      line_data_out <= ais_active || payload_bit;
      framer_loop_data_out <= payload_bit;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      all_ones_alarm_out <= 1'b0;
      remote_alarm_out <= 1'b0;
      mf_remote_alarm_out <= 1'b0;
    end else begin
      all_ones_alarm_out <= ais_active;
      remote_alarm_out <= remote_active;
      mf_remote_alarm_out <= mf_active;
    end
  end

  property p_ais_ones;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && ais_active |=> line_data_out;
  endproperty
  a_ais_ones: assert property (p_ais_ones)
    else $error("AIS bit not sent as one");

  property p_loop_path_kept;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && ais_active |=> framer_loop_data_out == $past(payload_bit);
  endproperty
  a_loop_path_kept: assert property (p_loop_path_kept)
    else $error("Framer loopback data altered by AIS");

  property p_auto_all_ones_alarm_digital;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    tx_alarm_config.auto_all_ones_alarm && mode_in.digital_line_select &&
    loss_in.rx_clock_loss |=> all_ones_alarm_out;
  endproperty
  a_auto_all_ones_alarm_digital: assert property (p_auto_all_ones_alarm_digital)
    else $error("Auto_all_ones_alarm missing on receive clock loss");

  property p_auto_no_switch;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    !tx_alarm_config.manual_all_ones_alarm && !loss_in.tx_clock_loss
    |=> tx_clock_out == $past(pins[PIN_TX_CLK]);
  endproperty
  a_auto_no_switch: assert property (p_auto_no_switch)
    else $error("Transmit clock switched without manual AIS");

  property p_clk_loss_ais;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && mode_in.alarm_clock_switch_en && loss_in.tx_clock_loss
    |=> line_data_out;
  endproperty
  a_clk_loss_ais: assert property (p_clk_loss_ais)
    else $error("No AIS during transmit clock loss");

  property p_t1_frame_hold;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    mode_in.t1_mode && tx_test_pattern_config.framed &&
    bit_pos == T1_FRAME_BIT_POS |-> !prbs_step;
  endproperty
  a_t1_frame_hold: assert property (p_t1_frame_hold)
    else $error("PRBS advanced on T1 frame bit");

  property p_e1_slot_hold;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && !mode_in.t1_mode && tx_test_pattern_config.framed &&
    bit_pos[7:3] == E1_TS_FRAMING && !loop_use
    |=> framer_loop_data_out == $past(yellow_force || src_bit);
  endproperty
  a_e1_slot_hold: assert property (p_e1_slot_hold)
    else $error("PRBS written into E1 time slot 0");

  property p_pattern_gate;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    !tx_test_pattern_config.pattern_tx_enable |-> !prbs_step;
  endproperty
  a_pattern_gate: assert property (p_pattern_gate)
    else $error("PRBS stepped while disabled");

  property p_loop_wrap;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && loop_use && loop_idx == loop_last |=> loop_idx == 3'h0;
  endproperty
  a_loop_wrap: assert property (p_loop_wrap)
    else $error("Loop code length not honoured");

  property p_loop_bit;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && loop_use |=>
    framer_loop_data_out == $past(tx_loop_code_pattern[7 - loop_idx]);
  endproperty
  a_loop_bit: assert property (p_loop_bit)
    else $error("Loop code bit order wrong");

  property p_mf_yellow;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && pins[PIN_MF_POS] && mf_active && !prbs_use && !loop_use
    |=> framer_loop_data_out;
  endproperty
  a_mf_yellow: assert property (p_mf_yellow)
    else $error("Multiframe yellow not inserted");

  property p_yellow_pass;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    bit_strobe && !remote_active && !mf_active && !prbs_use && !loop_use
    |=> framer_loop_data_out == $past(src_bit);
  endproperty
  a_yellow_pass: assert property (p_yellow_pass)
    else $error("Data altered with yellow inactive");

  c_ais: cover property (@(posedge ref_clk_in) bit_strobe && ais_active);
  c_prbs: cover property (@(posedge ref_clk_in) prbs_step);
  c_loop_wrap: cover property (@(posedge ref_clk_in)
    bit_strobe && loop_use && loop_idx == loop_last);
  c_alt_clk: cover property (@(posedge ref_clk_in) use_alt_clk);

endmodule : tatpg_tx_alarm
`default_nettype wire

// *** testbench/tatpg_line_model.sv ***
// Far-end line timing model: line clocks and frame positions
`timescale 1ns/100ps
`default_nettype none
module tatpg_line_model (
  input wire logic ref_clk_in,
  input wire logic t1_mode_in,
  output logic tx_clock_out,
  output logic alternate_tx_clock_out,
  output logic frame_sync_out,
  output logic remote_alarm_pos_out,
  output logic mf_remote_alarm_pos_out
);
  logic [7:0] pos = 8'h00;
  logic [3:0] ph = 4'h0;
  // Alarm slots are arbitrary stand-ins for the formatter
  // channel-24 yellow left to buffer traffic
  assign frame_sync_out = (pos == 8'h00);
  assign remote_alarm_pos_out = (pos == 8'h01);
  assign mf_remote_alarm_pos_out = (pos == 8'h02);
  // Line clock 320 ns, alternate 640 ns so a switch is visible
  assign tx_clock_out = ph[2];
  assign alternate_tx_clock_out = ph[3];
  always @(negedge ref_clk_in) begin
    ph <= ph + 4'h1;
    if (ph[2:0] == 3'h3) begin
      pos <= (t1_mode_in && pos == 8'hC0) ? 8'h00 : pos + 8'h01;
    end
  end
endmodule : tatpg_line_model
`default_nettype wire

// *** testbench/tatpg_tx_alarm_bench.sv ***
// Self-checking bench of the transmit alarm and test pattern block
`timescale 1ns/100ps
`default_nettype none
module tatpg_tx_alarm_bench;
  import tatpg_pkg::*;
  localparam logic [15:0] T1N = 16'h00C1;
  localparam logic [15:0] E1N = 16'h0100;
  localparam logic [7:0] CODE_BITS = 8'hD1;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sys_data = 1'b0;
  logic rx_loop = 1'b0;
  tatpg_mode_s mode = '0;
  tatpg_loss_s loss = '0;
  logic [7:0] rdata, rv;
  logic tx_clk, alt_clk, fsync, ra_pos, mf_pos;
  logic line, loop_data, tclk, ais, ra, mf;
  logic s [256];
  logic f [256];
  logic [7:0] ps [256];
  logic [7:0] msk [5] = '{8'h3F, 8'h1F, 8'h0F, 8'hFE, 8'h00};
  int lg [4] = '{11, 15, 20, 23};
  int tp [4] = '{9, 14, 17, 18};
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  int bad, run, mx, hit, flen;

  tatpg_tx_alarm tatpg_tx_alarm_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .cpu_addr_in(addr), .cpu_wr_in(wr), .cpu_rd_in(rd),
    .cpu_wdata_in(wdata), .cpu_rdata_out(rdata),
    .tx_clock_in(tx_clk), .alternate_tx_clock_in(alt_clk),
    .frame_sync_in(fsync), .sys_tx_data_in(sys_data),
    .rx_loop_data_in(rx_loop), .remote_alarm_pos_in(ra_pos),
    .mf_remote_alarm_pos_in(mf_pos), .mode_in(mode), .loss_in(loss),
    .line_data_out(line), .framer_loop_data_out(loop_data),
    .tx_clock_out(tclk), .all_ones_alarm_out(ais),
    .remote_alarm_out(ra), .mf_remote_alarm_out(mf));

  tatpg_line_model tatpg_line_model_i (
    .ref_clk_in(ref_clk_in), .t1_mode_in(mode.t1_mode),
    .tx_clock_out(tx_clk), .alternate_tx_clock_out(alt_clk),
    .frame_sync_out(fsync), .remote_alarm_pos_out(ra_pos),
    .mf_remote_alarm_pos_out(mf_pos));

  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // Whole run needs about 70000 cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("Error at %0t: run timed out", $time);
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk_in);
    wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_in);
    rd = 1'b0;
    @(negedge ref_clk_in);
    d = rdata;
  endtask : reg_rd

  // One sample per bit time; 16 bits of settling cover sync and switch
  task automatic collect(input int n);
    repeat (128) @(negedge ref_clk_in);
    // Sample mid-bit, so the model position matches the bit shown
    @(posedge tx_clk);
    repeat (4) @(negedge ref_clk_in);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(negedge ref_clk_in);
      s[i] = line;
      f[i] = loop_data;
      ps[i] = tatpg_line_model_i.pos;
    end
  endtask : collect

  function automatic logic [15:0] ones(input int n, input logic fl);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < n; i++) begin
      c = c + {15'h0000, (fl ? f[i] : s[i])};
    end
    return c;
  endfunction : ones

  task automatic fr(input logic [15:0] el, input logic [15:0] ef);
    flen = mode.t1_mode ? 193 : 256;
    collect(flen);
    check(ones(flen, 1'b0), el, "line ones per frame");
    check(ones(flen, 1'b1), ef, "loop ones per frame");
  endtask : fr

  task automatic clk_chk(input int exp);
    logic p;
    int n;
    n = 0;
    repeat (64) @(negedge ref_clk_in);
    p = tclk;
    repeat (256) begin
      @(negedge ref_clk_in);
      if (tclk === 1'b1 && p === 1'b0) n++;
      p = tclk;
    end
    check({15'h0000, (n >= exp - 1 && n <= exp + 1)}, 16'h0001, "clock");
  endtask : clk_chk

  initial begin
    repeat (20) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    for (int i = 0; i < 5; i++) begin
      reg_rd(8'h75 + i[7:0], rv);
      check({8'h00, rv}, 16'h0000, "reset value");
      reg_wr(8'h75 + i[7:0], 8'hFF);
      reg_rd(8'h75 + i[7:0], rv);
      check({8'h00, rv}, {8'h00, msk[i]}, "writable bits");
      reg_wr(8'h75 + i[7:0], 8'h00);
    end
    $display("Test registers finished");
    mode.t1_mode = 1'b1;
    sys_data = 1'b1;
    fr(T1N, T1N);
    sys_data = 1'b0;
    mode.remote_alarm_insert_en = 1'b1;
    reg_wr(8'h75, 8'h02);
    fr(16'h0001, 16'h0001);
    check({15'h0000, ra}, 16'h0001, "yellow state");
    reg_wr(8'h75, 8'h10);
    loss.rx_frame_align_loss = 1'b1;
    fr(16'h0001, 16'h0001);
    loss.rx_frame_align_loss = 1'b0;
    fr(16'h0000, 16'h0000);
    mode.remote_alarm_insert_en = 1'b0;
    reg_wr(8'h75, 8'h02);
    fr(16'h0000, 16'h0000);
    mode = '0;
    mode.mf_remote_alarm_insert_en = 1'b1;
    reg_wr(8'h75, 8'h04);
    fr(16'h0001, 16'h0001);
    reg_wr(8'h75, 8'h20);
    loss.rx_cas_align_loss = 1'b1;
    fr(16'h0001, 16'h0001);
    check({15'h0000, mf}, 16'h0001, "mf yellow state");
    loss = '0;
    fr(16'h0000, 16'h0000);
    $display("Test yellow finished");
    mode.line_loopback = 1'b1;
    reg_wr(8'h75, 8'h01);
    fr(E1N, 16'h0000);
    check({15'h0000, ais}, 16'h0001, "all ones state");
    mode.line_loopback = 1'b0;
    reg_wr(8'h75, 8'h08);
    for (int i = 0; i < 4; i++) begin
      mode.digital_line_select = i[1];
      loss.rx_signal_loss = ~i[0];
      loss.rx_clock_loss = i[0];
      fr((i[0] ^ i[1]) ? 16'h0000 : E1N, 16'h0000);
    end
    loss = '0;
    mode.digital_line_select = 1'b0;
    mode.alarm_clock_switch_en = 1'b1;
    reg_wr(8'h75, 8'h01);
    clk_chk(16);
    reg_wr(8'h75, 8'h08);
    loss.rx_signal_loss = 1'b1;
    clk_chk(32);
    loss = '0;
    reg_wr(8'h75, 8'h00);
    loss.tx_clock_loss = 1'b1;
    clk_chk(16);
    fr(E1N, 16'h0000);
    loss = '0;
    mode.alarm_clock_switch_en = 1'b0;
    reg_wr(8'h75, 8'h01);
    clk_chk(32);
    reg_wr(8'h75, 8'h00);
    $display("Test all ones finished");
    for (int k = 0; k < 8; k++) begin
      reg_wr(8'h76, {4'h1, 1'b0, k[2], k[1:0]});
      collect(256);
      bad = 0;
      run = 0;
      mx = 0;
      for (int n = 0; n < 256; n++) begin
        run = s[n] ? 0 : run + 1;
        if (run > mx) mx = run;
        if (n >= 23 && s[n] !== (s[n - lg[k % 4]] ^ s[n - tp[k % 4]] ^
            k[0])) bad++;
      end
      if (k < 4) begin
        check(16'(bad), 16'h0000, "prbs sequence");
      end else begin
        check({15'h0000, mx <= (k[1] ? 14 : 7)}, 16'h0001, "zeros");
      end
    end
    reg_wr(8'h76, 8'h00);
    $display("Test pattern finished");
    mode.t1_mode = 1'b1;
    reg_wr(8'h78, CODE_BITS);
    for (int l = 0; l < 4; l++) begin
      reg_wr(8'h77, {4'h0, l[1:0], 2'h3});
      collect(193);
      hit = 0;
      for (int p = 0; p < l + 4; p++) begin
        bad = 0;
        for (int n = 0; n < 193; n++) begin
          if (s[n] !== CODE_BITS[7 - (n + p) % (l + 4)]) bad++;
        end
        if (bad == 0) hit++;
      end
      check(16'(hit), 16'h0001, "loop code phase");
    end
    reg_wr(8'h78, 8'h00);
    sys_data = 1'b1;
    reg_wr(8'h77, 8'h01);
    fr(16'h0001, 16'h0001);
    reg_wr(8'h77, 8'h03);
    fr(16'h0000, 16'h0000);
    reg_wr(8'h77, 8'h02);
    fr(T1N, T1N);
    sys_data = 1'b0;
    reg_wr(8'h78, 8'hFE);
    reg_wr(8'h77, 8'h01);
    fr(16'h00C0, 16'h00C0);
    reg_wr(8'h78, 8'h00);
    sys_data = 1'b1;
    reg_wr(8'h77, 8'h03);
    reg_wr(8'h75, 8'h01);
    fr(T1N, 16'h0000);
    reg_wr(8'h75, 8'h00);
    reg_wr(8'h77, 8'h00);
    $display("Test loop code finished");
    mode.cas_framing = 1'b1;
    reg_wr(8'h76, 8'h18);
    for (int m = 1; m >= 0; m--) begin
      mode.t1_mode = m[0];
      flen = m ? 193 : 256;
      collect(flen);
      bad = 0;
      hit = 0;
      for (int n = 0; n < flen; n++) begin
        run = (m == 1) ? (ps[n] == 8'h00) :
          (ps[n][7:3] == 5'h00 || ps[n][7:3] == 5'h10);
        if (run != 0) begin
          hit++;
          if (s[n] !== 1'b1) bad++;
        end
      end
      check(16'(bad), 16'h0000, "framing kept");
      check(16'(hit), m ? 16'h0001 : 16'h0010, "slot count");
    end
    reg_wr(8'h76, 8'h00);
    $display("Test framed pattern finished");
    results();
  end
endmodule : tatpg_tx_alarm_bench
`default_nettype wire
